// File: common/tdp_cfg.svh
// constants for the two-wire potentiometer slave: address, opcodes, field positions, timing
// assumes it is included by bare name, by the design and by the bench
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH

// device-type code in the upper address nibble; value is arbitrary
`define TDP_TYPE_CODE   4'ha

// instruction codes, upper nibble of the command byte
`define TDP_OP_RD_WPR   4'h9
`define TDP_OP_WR_WPR   4'ha
`define TDP_OP_RD_SAV   4'hb
`define TDP_OP_WR_SAV   4'hc
`define TDP_OP_XF_S2W   4'hd
`define TDP_OP_XF_W2S   4'he
`define TDP_OP_GX_S2W   4'h1
`define TDP_OP_GX_W2S   4'h8
`define TDP_OP_INCDEC   4'h2

// command byte field positions
`define TDP_OP_MSB      7
`define TDP_OP_LSB      4
`define TDP_CH_SEL_HI   3
`define TDP_CH_SEL_LO   2
`define TDP_REG_SEL_HI  1
`define TDP_REG_SEL_LO  0

// bit counter marks and wiper limits
`define TDP_LAST_BIT    4'h7
`define TDP_ACK_BIT     4'h8
`define TDP_WIPER_MAX   6'h3f
`define TDP_WIPER_MIN   6'h00

// reset values
`define TDP_WIPER_RST   6'h00
`define TDP_SAVED_RST   6'h00
`define TDP_TAP_RST     64'h0000_0000_0000_0001

// nonvolatile write time and core clock rate
`define TDP_TWR_US      5000
`define TDP_CLK_MHZ     40

`endif

// File: common/tdp_pkg.sv
// types shared by the potentiometer slave: link state, core state, pin carriers
// assumes tdp_cfg.svh holds the numbers
`default_nettype none

package tdp_pkg;

	typedef enum logic [2:0] {
		TDP_ST_IDLE,
		TDP_ST_ADDR,
		TDP_ST_CMD,
		TDP_ST_DATA,
		TDP_ST_READ,
		TDP_ST_INCDEC,
		TDP_ST_IGNORE
	} tdp_link_state_type;

	// open-drain data pin drive: o is always low, oe pulls the line
	typedef struct packed {
		logic o;
		logic oe;
	} tdp_sda_type;

	typedef logic [3:0][63:0] tdp_taps_type;

	// state clocked by the falling serial clock
	typedef struct packed {
		tdp_link_state_type  state;
		logic [3:0]          bitcnt;
		logic [7:0]          shift;
		logic [7:0]          cmd;
		logic [7:0]          rdata;
		logic [3:0][5:0]     wiper;
		logic [3:0][3:0][5:0] saved;
		logic                start_ack;
		logic                stop_ack;
		logic                pub_tog;
		logic                nv_tog;
		logic                busy_s1;
		logic                busy_s2;
		logic [3:0]          strap_s1;
		logic [3:0]          strap_s2;
		tdp_sda_type         sda;
	} tdp_link_type;

	// state clocked by the core clock
	typedef struct packed {
		logic [2:0]   stop_s;
		logic [2:0]   nv_s;
		logic [2:0]   pub_s;
		logic         armed;
		logic         busy;
		logic [17:0]  cnt;
		tdp_taps_type taps;
	} tdp_core_type;

endpackage

`default_nettype wire

// File: logic/tdp_tap_decoder.sv
// one-of-64 tap decoder for one potentiometer channel
// assumes a 6-bit wiper position that is stable while it is sampled
`default_nettype none

module tdp_tap_decoder (
	input  wire logic [5:0]  pos,
	output logic      [63:0] onehot
);

	// a single shifted one: never two taps on, tap 0 and 63 are the array ends
	assign onehot = 64'h0000_0000_0000_0001 << pos; // R14 R15 R16

endmodule

`default_nettype wire

// File: logic/tdp_slave_top.sv
// two-wire slave front end and wiper/saved registers of a quad digital potentiometer
// assumes scl and sda come from pins, the master owns scl, and straps are static
//
// Functional notes
// R1: data changes only while clock low; high-clock edges mean start or stop
// R2: start is data falling with clock high; each command begins with start
// R3: both lines watched always; nothing answered before a start
// R4: master ends each transaction with stop, data rising while clock high
// R5: transmitter releases data line after eight bits for the answer
// R6: ninth clock carries the receiver pulling data low as acknowledge
// R7: matching address after start is acknowledged on the ninth clock
// R8: command byte after the address is acknowledged on its ninth clock
// R9: a data byte after the command gets a final acknowledge
// R10: address follows start; eight bits, upper nibble is the type code
// R11: four strap inputs give the low address nibble
// R12: address acknowledged only when all four low bits equal the straps
// R13: each of four channels has its own wiper position register
// R14: six wiper bits decode into one-hot selection of 64 taps
// R15: never more than one tap switch on within a channel
// R16: 63 segments per array; taps 0 and 63 are the array ends
// R17: wiper loads by direct write or copy of one saved register
// R18: wiper and saved registers both readable and writable over the bus
// R19: master starts every transfer and drives the clock; device never does
// R20: data pin only pulled low, released otherwise for the pull-up
// R21: command byte: opcode nibble, two channel bits, two register bits
// R22: address not acknowledged while a nonvolatile write runs after stop
// R23: after inc/dec ack, each clock with data high steps up, low down
// R24: address mismatch leaves data released until next start
// R25: start or stop mid-byte aborts without register change, bit count resyncs
`default_nettype none
`include "tdp_cfg.svh"

module tdp_slave_top
	import tdp_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `TDP_TWR_US * `TDP_CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        scl,
	input  wire logic        sda_i,
	input  wire logic [3:0]  addr_strap_pins,
	output var  tdp_sda_type sda_drv,
	output var  tdp_taps_type tap_sel
);

	tdp_link_type lk_reg;
	tdp_link_type lk_next;
	tdp_core_type core_reg;
	tdp_core_type core_next;
	logic         start_tog_reg;
	logic         stop_tog_reg;
	logic         bit_smp_reg;
	logic         start_pend;
	logic         stop_pend;
	logic [7:0]   rx_byte;
	logic         addr_hit;
	logic         pub_evt;
	tdp_taps_type dec_out;

	function automatic logic op_known(input logic [3:0] op);
		case (op)
			`TDP_OP_RD_WPR, `TDP_OP_WR_WPR, `TDP_OP_RD_SAV, `TDP_OP_WR_SAV,
			`TDP_OP_XF_S2W, `TDP_OP_XF_W2S, `TDP_OP_GX_S2W, `TDP_OP_GX_W2S,
			`TDP_OP_INCDEC: op_known = 1'b1;
			default: op_known = 1'b0;
		endcase
	endfunction

	function automatic logic op_reads(input logic [3:0] op);
		op_reads = (op == `TDP_OP_RD_WPR) || (op == `TDP_OP_RD_SAV);
	endfunction

	function automatic logic op_writes(input logic [3:0] op);
		op_writes = (op == `TDP_OP_WR_WPR) || (op == `TDP_OP_WR_SAV);
	endfunction

	// start/stop detectors run on the data line edges; only these see high-clock changes
	always_ff @(negedge sda_i or posedge rst) begin
		if (rst) begin
			start_tog_reg <= 1'b0;
		end else if (scl) begin
			start_tog_reg <= ~start_tog_reg; // R1 R2
		end
	end

	always_ff @(posedge sda_i or posedge rst) begin
		if (rst) begin
			stop_tog_reg <= 1'b0;
		end else if (scl) begin
			stop_tog_reg <= ~stop_tog_reg; // R1 R4
		end
	end

	// data is sampled on the rising clock, acted on at the falling one
	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			bit_smp_reg <= 1'b0;
		end else begin
			bit_smp_reg <= sda_i; // R1
		end
	end

	// toggles are protocol-timed: a start/stop edge settles a hold time before scl falls
	assign start_pend = start_tog_reg ^ lk_reg.start_ack;
	assign stop_pend  = stop_tog_reg ^ lk_reg.stop_ack;
	assign rx_byte    = {lk_reg.shift[6:0], bit_smp_reg};
	assign addr_hit   = (rx_byte == {`TDP_TYPE_CODE, lk_reg.strap_s2}); // R10 R11 R12

	// link engine: bit counting, acknowledge, register access
	always_comb begin
		lk_next          = lk_reg;
		lk_next.strap_s1 = addr_strap_pins;
		lk_next.strap_s2 = lk_reg.strap_s1;
		lk_next.busy_s1  = core_reg.busy;
		lk_next.busy_s2  = lk_reg.busy_s1;
		lk_next.sda.o    = 1'b0; // R20
		if (start_pend) begin
			// start wins over a stop seen in the same high phase
			lk_next.state     = TDP_ST_ADDR; // R2 R3 R25
			lk_next.bitcnt    = 4'h0;
			lk_next.sda.oe    = 1'b0;
			lk_next.start_ack = start_tog_reg;
			lk_next.stop_ack  = stop_tog_reg;
		end else if (stop_pend) begin
			lk_next.state    = TDP_ST_IDLE; // R4 R25
			lk_next.bitcnt   = 4'h0;
			lk_next.sda.oe   = 1'b0;
			lk_next.stop_ack = stop_tog_reg;
		end else begin
			case (lk_reg.state)
				TDP_ST_IDLE, TDP_ST_IGNORE: begin
					lk_next.sda.oe = 1'b0; // R3 R24
				end
				TDP_ST_ADDR, TDP_ST_CMD, TDP_ST_DATA: begin
					if (lk_reg.bitcnt == `TDP_ACK_BIT) begin
						// end of ninth clock: release, or drive the first read bit, and move on
						lk_next.sda.oe = 1'b0; // R5
						lk_next.bitcnt = 4'h0;
						if (!lk_reg.sda.oe) begin
							lk_next.state = TDP_ST_IGNORE; // R24
						end else if (lk_reg.state == TDP_ST_ADDR) begin
							lk_next.state = TDP_ST_CMD;
						end else if (lk_reg.state == TDP_ST_DATA) begin
							lk_next.state = TDP_ST_IGNORE;
						end else if (op_reads(lk_reg.cmd[`TDP_OP_MSB:`TDP_OP_LSB])) begin
							lk_next.state  = TDP_ST_READ; // R18
							lk_next.sda.oe = ~lk_reg.rdata[7];
						end else if (op_writes(lk_reg.cmd[`TDP_OP_MSB:`TDP_OP_LSB])) begin
							lk_next.state = TDP_ST_DATA;
						end else if (lk_reg.cmd[`TDP_OP_MSB:`TDP_OP_LSB] == `TDP_OP_INCDEC) begin
							lk_next.state = TDP_ST_INCDEC; // R23
						end else begin
							lk_next.state = TDP_ST_IGNORE;
						end
					end else if (lk_reg.bitcnt == `TDP_LAST_BIT) begin
						// eighth bit in: decide the acknowledge for the ninth clock
						lk_next.shift  = rx_byte;
						lk_next.bitcnt = `TDP_ACK_BIT;
						if (lk_reg.state == TDP_ST_ADDR) begin
							lk_next.sda.oe = addr_hit && !lk_reg.busy_s2; // R7 R12 R22
						end else if (lk_reg.state == TDP_ST_CMD) begin
							lk_next.cmd    = rx_byte; // R21
							lk_next.sda.oe = op_known(rx_byte[`TDP_OP_MSB:`TDP_OP_LSB]); // R6 R8
							case (rx_byte[`TDP_OP_MSB:`TDP_OP_LSB])
								`TDP_OP_RD_WPR: begin
									lk_next.rdata = {2'h0, lk_reg.wiper[rx_byte[3:2]]};
								end
								`TDP_OP_RD_SAV: begin
									lk_next.rdata = {2'h0, lk_reg.saved[rx_byte[3:2]][rx_byte[1:0]]};
								end
								`TDP_OP_XF_S2W: begin
									lk_next.wiper[rx_byte[3:2]] = lk_reg.saved[rx_byte[3:2]][rx_byte[1:0]]; // R17
									lk_next.pub_tog = ~lk_reg.pub_tog;
								end
								`TDP_OP_XF_W2S: begin
									lk_next.saved[rx_byte[3:2]][rx_byte[1:0]] = lk_reg.wiper[rx_byte[3:2]];
									lk_next.nv_tog = ~lk_reg.nv_tog;
								end
								`TDP_OP_GX_S2W: begin
									for (int i = 0; i < 4; i++) begin
										lk_next.wiper[i] = lk_reg.saved[i][rx_byte[1:0]]; // R17
									end
									lk_next.pub_tog = ~lk_reg.pub_tog;
								end
								`TDP_OP_GX_W2S: begin
									for (int i = 0; i < 4; i++) begin
										lk_next.saved[i][rx_byte[1:0]] = lk_reg.wiper[i];
									end
									lk_next.nv_tog = ~lk_reg.nv_tog;
								end
								default: begin
									lk_next.rdata = lk_reg.rdata;
								end
							endcase
						end else begin
							lk_next.sda.oe = 1'b1; // R9
							if (lk_reg.cmd[`TDP_OP_MSB:`TDP_OP_LSB] == `TDP_OP_WR_WPR) begin
								lk_next.wiper[lk_reg.cmd[3:2]] = rx_byte[5:0]; // R17 R18
								lk_next.pub_tog = ~lk_reg.pub_tog;
							end else begin
								lk_next.saved[lk_reg.cmd[3:2]][lk_reg.cmd[1:0]] = rx_byte[5:0]; // R18
								lk_next.nv_tog = ~lk_reg.nv_tog;
							end
						end
					end else begin
						lk_next.shift  = rx_byte;
						lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
					end
				end
				TDP_ST_READ: begin
					// single byte out, msb first; the master's ninth bit is not checked
					if (lk_reg.bitcnt == `TDP_ACK_BIT) begin
						lk_next.state  = TDP_ST_IGNORE;
						lk_next.bitcnt = 4'h0;
					end else if (lk_reg.bitcnt == `TDP_LAST_BIT) begin
						lk_next.sda.oe = 1'b0; // R5
						lk_next.bitcnt = `TDP_ACK_BIT;
					end else begin
						lk_next.rdata  = {lk_reg.rdata[6:0], 1'b0};
						lk_next.sda.oe = ~lk_reg.rdata[6]; // R20
						lk_next.bitcnt = lk_reg.bitcnt + 4'h1;
					end
				end
				TDP_ST_INCDEC: begin
					// saturate at the array ends rather than wrap
					if (bit_smp_reg && lk_reg.wiper[lk_reg.cmd[3:2]] != `TDP_WIPER_MAX) begin
						lk_next.wiper[lk_reg.cmd[3:2]] = lk_reg.wiper[lk_reg.cmd[3:2]] + 6'h01; // R23
						lk_next.pub_tog = ~lk_reg.pub_tog;
					end else if (!bit_smp_reg && lk_reg.wiper[lk_reg.cmd[3:2]] != `TDP_WIPER_MIN) begin
						lk_next.wiper[lk_reg.cmd[3:2]] = lk_reg.wiper[lk_reg.cmd[3:2]] - 6'h01; // R23
						lk_next.pub_tog = ~lk_reg.pub_tog;
					end
				end
				default: begin
					lk_next.state = TDP_ST_IDLE;
				end
			endcase
		end
	end

	// falling scl carries all link state, so the pin changes only while scl is low
	always_ff @(negedge scl or posedge rst) begin
		if (rst) begin
			lk_reg       <= '0;
			lk_reg.wiper <= {4{`TDP_WIPER_RST}}; // R13
			lk_reg.saved <= {16{`TDP_SAVED_RST}};
		end else begin
			lk_reg <= lk_next;
		end
	end

	// one decoder per channel, read only when a publish toggle has crossed
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tap
			tdp_tap_decoder u_dec (
				.pos    (lk_reg.wiper[gi]), // R13
				.onehot (dec_out[gi])
			);
		end
	endgenerate

	assign pub_evt = core_reg.pub_s[2] ^ core_reg.pub_s[1];

	// core side: toggle synchronisers, tap capture, nonvolatile write timer
	always_comb begin
		core_next = core_reg;
		if (ce) begin
			core_next.stop_s = {core_reg.stop_s[1:0], stop_tog_reg};
			core_next.nv_s   = {core_reg.nv_s[1:0], lk_reg.nv_tog};
			core_next.pub_s  = {core_reg.pub_s[1:0], lk_reg.pub_tog};
			if (pub_evt) begin
				core_next.taps = dec_out; // R14 R15
			end
			if (core_reg.nv_s[2] ^ core_reg.nv_s[1]) begin
				core_next.armed = 1'b1;
			end
			if ((core_reg.stop_s[2] ^ core_reg.stop_s[1]) && core_reg.armed) begin
				core_next.busy  = 1'b1; // R22
				core_next.cnt   = 18'h0;
				core_next.armed = 1'b0;
			end else if (core_reg.busy) begin
				if (core_reg.cnt == 18'(WRITE_CYCLES - 1)) begin
					core_next.busy = 1'b0;
				end else begin
					core_next.cnt = core_reg.cnt + 18'h1;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_reg      <= '0;
			core_reg.taps <= {4{`TDP_TAP_RST}};
		end else begin
			core_reg <= core_next;
		end
	end

	assign sda_drv = lk_reg.sda;
	assign tap_sel = core_reg.taps;

	// link checks
	a_addr_ack: assert property (@(negedge scl) disable iff (rst) // R7 R12
		(!start_pend && !stop_pend && lk_reg.state == TDP_ST_ADDR &&
		 lk_reg.bitcnt == `TDP_LAST_BIT)
		|=> (lk_reg.sda.oe == ($past(addr_hit) && !$past(lk_reg.busy_s2))))
		else $error("address acknowledge wrong");

	a_busy_nack: assert property (@(negedge scl) disable iff (rst) // R22
		(lk_reg.busy_s2 && !start_pend && !stop_pend && lk_reg.state == TDP_ST_ADDR &&
		 lk_reg.bitcnt == `TDP_LAST_BIT) |=> !lk_reg.sda.oe ##1 lk_reg.state != TDP_ST_CMD)
		else $error("address acknowledged while busy");

	a_ack_release: assert property (@(negedge scl) disable iff (rst) // R5
		(!start_pend && !stop_pend && lk_reg.bitcnt == `TDP_ACK_BIT &&
		 lk_reg.state inside {TDP_ST_ADDR, TDP_ST_DATA})
		|=> (!lk_reg.sda.oe && lk_reg.bitcnt == 4'h0))
		else $error("acknowledge not released");

	a_quiet_ignore: assert property (@(negedge scl) disable iff (rst) // R24
		(lk_reg.state == TDP_ST_IGNORE && !start_pend) |=> !lk_reg.sda.oe [*2])
		else $error("data driven while ignoring");

	a_start_sync: assert property (@(negedge scl) disable iff (rst) // R25
		start_pend |=> (lk_reg.state == TDP_ST_ADDR && lk_reg.bitcnt == 4'h0 && !lk_reg.sda.oe))
		else $error("start did not resync");

	a_stop_idle: assert property (@(negedge scl) disable iff (rst) // R4
		(stop_pend && !start_pend) |=> (lk_reg.state == TDP_ST_IDLE && $stable(lk_reg.saved)))
		else $error("stop did not abort");

	a_incdec_step: assert property (@(negedge scl) disable iff (rst) // R23
		(lk_reg.state == TDP_ST_INCDEC && !start_pend && !stop_pend && bit_smp_reg &&
		 lk_reg.wiper[lk_reg.cmd[3:2]] != `TDP_WIPER_MAX)
		|=> lk_reg.wiper[lk_reg.cmd[3:2]] == $past(lk_reg.wiper[lk_reg.cmd[3:2]]) + 6'h01)
		else $error("wiper did not step up");

	// core checks
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chk
			a_tap_onehot: assert property (@(posedge clk) disable iff (rst) // R15
				$onehot(core_reg.taps[gi]))
				else $error("tap decoder not one-hot");
		end
	endgenerate

	a_tap_track: assert property (@(posedge clk) disable iff (rst) // R14
		(ce && pub_evt) |=> core_reg.taps[0] == (64'h0000_0000_0000_0001 << $past(lk_reg.wiper[0])))
		else $error("tap selection does not follow wiper");

	a_busy_hold: assert property (@(posedge clk) disable iff (rst) // R22
		$rose(core_reg.busy) |-> core_reg.busy [*8])
		else $error("write busy too short");

	c_addr_ack: cover property (@(negedge scl) disable iff (rst)
		lk_reg.state == TDP_ST_ADDR && lk_reg.sda.oe);
	c_read_byte: cover property (@(negedge scl) disable iff (rst)
		lk_reg.state == TDP_ST_READ && lk_reg.bitcnt == `TDP_ACK_BIT);
	c_incdec: cover property (@(negedge scl) disable iff (rst)
		lk_reg.state == TDP_ST_INCDEC && $changed(lk_reg.pub_tog));
	c_busy: cover property (@(posedge clk) disable iff (rst) $fell(core_reg.busy));

endmodule

`default_nettype wire

// File: sim/tdp_master_bfm.sv
// two-wire bus master model: owns the serial clock and pulls the data line open-drain
// assumes an 80 ns serial period and a pull-up on the data wire in the bench
`default_nettype none

module tdp_master_bfm (
	output var  logic scl,
	output var  logic sda_oe,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int QTR = 20; // quarter of the serial period

	// bus idles high; clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// start or repeated start, entered with the clock low or idle
	task automatic start_c();
		sda_oe = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_oe = 1'b1;
		#QTR scl = 1'b0;
		#QTR;
	endtask

	// stop, entered with the clock low
	task automatic stop_c();
		sda_oe = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_oe = 1'b0;
		#(2 * QTR);
	endtask

	// one clock pulse; b high releases the line so the far side may answer
	task automatic bit_c(input logic b, output logic s);
		sda_oe = ~b;
		#QTR scl = 1'b1;
		#QTR s = sda;
		#QTR scl = 1'b0;
		#QTR;
	endtask

	// leave idle without a start, for traffic that must be ignored
	task automatic lead_c();
		scl = 1'b0;
		#QTR;
	endtask
endmodule

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench: bus master model drives the slave, a queue-free model predicts results
// assumes tdp_cfg.svh on the include path and the slave's bus timing
`default_nettype none
`include "tdp_cfg.svh"

module tb_top
	import tdp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned WCYC = 60; // short store time keeps polling visible
	localparam int DLY = 2;

	logic         clk, rst, ce, scl, mst_oe, a;
	logic [3:0]   straps;
	logic [7:0]   addr, v;
	tdp_sda_type  sda_drv;
	tdp_taps_type tap_sel;
	int           n_errors, comparisons, seed, cycles;
	int           wiper [4];
	int           saved [4][4];
	logic [3:0]   bad_ops [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
	logic [3:0]   xf_ops [4] = '{`TDP_OP_XF_S2W, `TDP_OP_XF_W2S, `TDP_OP_GX_S2W, `TDP_OP_GX_W2S};
	wire  logic   sda_line = ~(sda_drv.oe | mst_oe); // pull-up unless someone pulls low

	tdp_slave_top #(.WRITE_CYCLES(WCYC)) i_dut (
		.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda_line),
		.addr_strap_pins(straps), .sda_drv(sda_drv), .tap_sel(tap_sel));
	tdp_master_bfm i_mst (.scl(scl), .sda_oe(mst_oe), .sda(sda_line));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic fail(input string msg);
		n_errors++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask

	task automatic chk_ack(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) fail("acknowledge differs");
		comparisons++;
		if (sda_drv.o !== 1'b0) fail("data pin driven high");
	endtask

	task automatic chk_byte(input logic [7:0] got, input int exp);
		comparisons++;
		if (got !== 8'(exp)) fail("read byte differs");
	endtask

	task automatic chk_taps();
		for (int k = 0; k < 4; k++) begin
			comparisons++;
			if (tap_sel[k] !== (64'h1 << wiper[k])) fail("tap selection off its wiper");
		end
	endtask

	// msb first, then the ninth clock with the line released
	task automatic wr_byte(input logic [7:0] b, output logic ackd);
		logic s;
		for (int i = 7; i >= 0; i--) i_mst.bit_c(b[i], s);
		i_mst.bit_c(1'b1, s);
		ackd = ~s;
	endtask

	task automatic rd_byte(output logic [7:0] r);
		logic s;
		for (int i = 7; i >= 0; i--) i_mst.bit_c(1'b1, r[i]);
		i_mst.bit_c(1'b1, s); // master does not acknowledge the last byte
	endtask

	task automatic settle();
		repeat (90) @(posedge clk);
		#DLY;
	endtask

	// one complete command; model updated after the stop
	task automatic frame(input logic [3:0] op, input logic [1:0] ch, input logic [1:0] rs,
			input logic [7:0] dat);
		logic k;
		i_mst.start_c();
		wr_byte(addr, k);
		chk_ack(k, 1'b1);
		wr_byte({op, ch, rs}, k);
		chk_ack(k, 1'b1);
		if (op == `TDP_OP_WR_WPR || op == `TDP_OP_WR_SAV) begin
			wr_byte(dat, k);
			chk_ack(k, 1'b1);
		end else if (op == `TDP_OP_RD_WPR || op == `TDP_OP_RD_SAV) begin
			rd_byte(v);
			chk_byte(v, (op == `TDP_OP_RD_WPR) ? wiper[ch] : saved[ch][rs]);
		end
		i_mst.stop_c();
		case (op)
			`TDP_OP_WR_WPR: wiper[ch] = int'(dat[5:0]);
			`TDP_OP_WR_SAV: saved[ch][rs] = int'(dat[5:0]);
			`TDP_OP_XF_S2W: wiper[ch] = saved[ch][rs];
			`TDP_OP_XF_W2S: saved[ch][rs] = wiper[ch];
			`TDP_OP_GX_S2W: foreach (wiper[j]) wiper[j] = saved[j][rs];
			`TDP_OP_GX_W2S: foreach (wiper[j]) saved[j][rs] = wiper[j];
			default: ;
		endcase
		settle(); // also outlasts any nonvolatile store
		chk_taps();
	endtask

	// refused frame: after a refusal the device must stay silent
	task automatic nack(input logic [7:0] ab, input logic [7:0] cb, input logic exp);
		logic k;
		i_mst.start_c();
		wr_byte(ab, k);
		chk_ack(k, exp);
		wr_byte(cb, k);
		chk_ack(k, 1'b0);
		i_mst.stop_c();
	endtask

	task automatic steps(input logic up, input int n, input int exp);
		logic s;
		for (int i = 0; i < n; i++) i_mst.bit_c(up, s);
		wiper[2] = exp;
		settle(); // clock held low meanwhile
		chk_taps();
	endtask

	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail("run did not finish");
			summarize();
		end
	end

	initial begin
		seed = 59731;
		rst = 1'b0;
		ce = 1'b1;
		straps = 4'h0;
		n_errors = 0;
		comparisons = 0;
		foreach (wiper[j]) wiper[j] = 0;
		foreach (saved[j, r]) saved[j][r] = 0;
		// a clean rising edge, so every asynchronous reset branch sees it
		#DLY rst = 1'b1;
		repeat (6) @(posedge clk);
		#DLY rst = 1'b0;
		straps = 4'($random(seed));
		addr = {`TDP_TYPE_CODE, straps};
		repeat (4) @(posedge clk);
		#DLY;
		chk_taps();
		// traffic without a start goes unanswered
		i_mst.lead_c();
		wr_byte(addr, a);
		chk_ack(a, 1'b0);
		i_mst.stop_c();
		for (int k = 0; k < 8; k++) begin
			nack(addr ^ (8'h1 << k), {`TDP_OP_WR_WPR, 4'h0}, 1'b0);
		end
		for (int c = 0; c < 4; c++) begin
			frame(`TDP_OP_WR_WPR, 2'(c), 2'h0, 8'($random(seed)));
			for (int r = 0; r < 4; r++) frame(`TDP_OP_WR_SAV, 2'(c), 2'(r), 8'($random(seed)));
			frame(`TDP_OP_RD_WPR, 2'(c), 2'h0, 8'h00);
		end
		foreach (xf_ops[i]) frame(xf_ops[i], 2'($random(seed)), 2'($random(seed)), 8'h00);
		foreach (saved[c, r]) frame(`TDP_OP_RD_SAV, 2'(c), 2'(r), 8'h00);
		foreach (bad_ops[i]) nack(addr, {bad_ops[i], 4'h0}, 1'b1);
		// store, then poll at once: refused while busy, answered afterwards
		i_mst.start_c();
		wr_byte(addr, a);
		wr_byte({`TDP_OP_WR_SAV, 4'h5}, a);
		wr_byte(8'h15, a);
		i_mst.stop_c();
		saved[1][1] = 21;
		nack(addr, 8'h00, 1'b0);
		settle();
		frame(`TDP_OP_RD_SAV, 2'h1, 2'h1, 8'h00);
		// stop in mid-byte: nothing written, later pulses without a start unanswered
		i_mst.start_c();
		wr_byte(addr, a);
		wr_byte({`TDP_OP_WR_WPR, 4'h0}, a);
		for (int i = 0; i < 4; i++) i_mst.bit_c(1'b1, a);
		i_mst.stop_c();
		i_mst.lead_c();
		wr_byte(addr, a);
		chk_ack(a, 1'b0);
		i_mst.stop_c();
		// start in mid-byte: no register change, bit count restarts
		i_mst.start_c();
		wr_byte(addr, a);
		wr_byte({`TDP_OP_WR_WPR, 4'h0}, a);
		for (int i = 0; i < 4; i++) i_mst.bit_c(1'b0, a);
		i_mst.start_c();
		wr_byte(addr, a);
		chk_ack(a, 1'b1);
		wr_byte({`TDP_OP_RD_WPR, 4'h0}, a);
		rd_byte(v);
		chk_byte(v, wiper[0]);
		i_mst.stop_c();
		// clock enable low holds the taps; the held publish lands once it returns
		settle();
		ce = 1'b0;
		v = 8'($random(seed));
		i_mst.start_c();
		wr_byte(addr, a);
		chk_ack(a, 1'b1);
		wr_byte({`TDP_OP_WR_WPR, 4'hc}, a);
		chk_ack(a, 1'b1);
		wr_byte(v, a);
		chk_ack(a, 1'b1);
		i_mst.stop_c();
		settle();
		chk_taps();
		wiper[3] = int'(v[5:0]);
		ce = 1'b1;
		settle();
		chk_taps();
		// step up, down past zero, up past the top
		frame(`TDP_OP_WR_WPR, 2'h2, 2'h0, 8'd20);
		i_mst.start_c();
		wr_byte(addr, a);
		wr_byte({`TDP_OP_INCDEC, 4'h8}, a);
		chk_ack(a, 1'b1);
		steps(1'b1, 7, 27);
		steps(1'b0, 30, 0);
		steps(1'b1, 70, 63);
		i_mst.start_c(); // the start claims that pulse, so no step is taken
		i_mst.stop_c();
		settle();
		chk_taps();
		summarize();
	end
endmodule

`default_nettype wire
